// [include/kms_pkg.sv]
// package: constants for keyboard matrix scan and key-press detection
package kms_pkg;
   // external data addresses of the scan ports
   localparam logic [15:0] KMS_XADDR_LOW   = 16'hffff;
   localparam logic [15:0] KMS_XADDR_HIGH  = 16'hfffe;
   // register port offsets
   localparam logic [3:0]  KMS_REG_SCAN_LO = 4'h0;
   localparam logic [3:0]  KMS_REG_SCAN_HI = 4'h1;
   localparam logic [3:0]  KMS_REG_RETURN  = 4'h2;
   localparam logic [3:0]  KMS_REG_POWER_CONTROL_REGISTER    = 4'h3;
   localparam logic [3:0]  KMS_REG_STATUS  = 4'h4;
   localparam logic [3:0]  KMS_REG_VARIANT = 4'h5;
   // power control register field positions
   localparam int          KMS_POWER_CONTROL_REGISTER_IDLE   = 0;
   localparam int          KMS_POWER_CONTROL_REGISTER_PD     = 1;
   localparam int          KMS_POWER_CONTROL_REGISTER_KBMODE = 2;
   // status register field positions
   localparam int          KMS_ST_KEY      = 0;
   localparam int          KMS_ST_KEYPIN_N = 1;
   // reset values
   localparam logic [7:0]  KMS_SCAN_RST    = 8'hff;
   localparam logic [7:0]  KMS_POWER_CONTROL_REGISTER_RST    = 8'h00;
   localparam logic        KMS_VAR_RST     = 1'b0;
   // measurement instant after a scan step, capacitive variant
   localparam int          KMS_STROBE_NS   = 3000;
   localparam int          KMS_CLK_NS      = 25;
   localparam int          KMS_STROBE_CYC  = KMS_STROBE_NS / KMS_CLK_NS;
   typedef enum logic [1:0] {
      KMS_RUN   = 2'b00,
      KMS_IDLE  = 2'b01,
      KMS_PDOWN = 2'b11
   } kms_pwr_e;
endpackage

// [hw/kms_scan_detect.sv]
// design: keyboard matrix scan ports, return line sampling, key detect
// Functional notes
// R01 - software drives only one scan output low at any time
// R02 - software returns all scan outputs high between two active lines
// R03 - scanning rolls a single zero, one position per step
// R04 - return line comparator results readable after each scan step
// R05 - key-pressed indication on dedicated pin, readable flag and irq source
// R06 - key pin low while any key on scanned line pressed, else high
// R07 - key indication updates only after each new scan step starts (mechanical variant: key follows the return lines every cycle)
// R08 - software sets edge-select so external interrupt zero is edge triggered
// R09 - capacitive variant routes key indication internally to interrupt zero
// R10 - scan ports writable as registers and at two top data addresses
// R11 - data address ffff writes low port, fffe writes high port
// R12 - keyboard mode: external data moves give no strobes, address or data
// R13 - keyboard mode flag set selects keyboard mode, clear gives standard port
// R14 - romless system should map scan ports at the two top addresses
// R15 - rom version software should prefer register access to scan ports
// R16 - power-down stops clocks; idle gates cpu clock only
// R17 - mechanical power-down switches analog off; only reset exits
// R18 - mechanical idle: key press pulls pin low, wakes cpu if enabled
// R19 - capacitive: key indication holds until new scan value written
// R20 - capacitive: strobed result 0 if recharged, 1 if not
// R21 - key indication is or of all eight pressed return results
`timescale 1ns/10ps
module kms_scan_detect
   import kms_pkg::*;
#(
   parameter int SCAN_W    = 8,
   parameter int RET_W     = 8,
   parameter int STROBE_CY = KMS_STROBE_CYC
) (
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // register port
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [7:0]        reg_rdata_o,
   // external data move request from the cpu
   input  wire logic [15:0]       xmove_addr_i,
   input  wire logic [7:0]        xmove_wdata_i,
   input  wire logic              xmove_wr_i,
   input  wire logic              xmove_rd_i,
   // cpu interrupt enable for external interrupt zero
   input  wire logic              irq_zero_enable_i,
   // external bus strobes and address/data (standard mode)
   output logic                   xbus_wr_strobe_o,
   output logic                   xbus_rd_strobe_o,
   output logic      [15:0]       xbus_addr_o,
   output logic      [7:0]        xbus_wdata_o,
   // matrix side
   output logic      [SCAN_W-1:0] scan_out_low_port_o,
   output logic      [SCAN_W-1:0] scan_out_high_port_o,
   input  wire logic [RET_W-1:0]  return_line_port_i,
   output logic                   key_pressed_pin_n_o,
   output logic                   external_interrupt_zero_n_o,
   // power control
   output logic                   analog_power_on_o,
   output logic                   cpu_clock_run_o,
   output logic                   osc_run_o,
   output logic                   idle_wake_o
);

   localparam int CW = $clog2(STROBE_CY + 1);

   typedef struct packed {
      logic [SCAN_W-1:0] scan_lo;
      logic [SCAN_W-1:0] scan_hi;
      logic [RET_W-1:0]  ret_s1;
      logic [RET_W-1:0]  ret_s2;
      logic [RET_W-1:0]  ret_hold;
      logic              key;
      logic              step;
      logic [CW-1:0]     cnt;
      logic [7:0]        power_control_register;
      logic              variant;
      kms_pwr_e          pwr;
      logic [7:0]        rdata;
      logic              xwr;
      logic              xrd;
      logic [15:0]       xaddr;
      logic [7:0]        xdata;
   } kms_state_s;

   kms_state_s s_r;
   kms_state_s s_nxt;

   logic kbmode;
   logic any_pressed;
   logic scan_wr;

   assign kbmode = s_r.power_control_register[KMS_POWER_CONTROL_REGISTER_KBMODE]; // [R13]
   // comparator low means closed key on mechanical matrix
   assign any_pressed = |(~s_r.ret_s2); // [R21]

   always_comb begin
      s_nxt        = s_r;
      scan_wr      = 1'b0;
      s_nxt.ret_s1 = return_line_port_i;
      s_nxt.ret_s2 = s_r.ret_s1;
      s_nxt.step   = 1'b0;
      s_nxt.xwr    = 1'b0;
      s_nxt.xrd    = 1'b0;
      s_nxt.rdata  = 8'h00;
      // register port writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            KMS_REG_SCAN_LO: begin
               s_nxt.scan_lo = reg_wdata_i[SCAN_W-1:0]; // [R10]
               scan_wr       = 1'b1;
            end
            KMS_REG_SCAN_HI: begin
               s_nxt.scan_hi = reg_wdata_i[SCAN_W-1:0]; // [R10]
               scan_wr       = 1'b1;
            end
            KMS_REG_POWER_CONTROL_REGISTER: begin
               s_nxt.power_control_register = reg_wdata_i;
            end
            KMS_REG_VARIANT: begin
               s_nxt.variant = reg_wdata_i[0];
            end
            default: begin
            end
         endcase
      end
      // external data moves: keyboard mode captures the top two addresses
      // a register write to the same port in the same cycle wins
      if (xmove_wr_i && kbmode) begin
         if (xmove_addr_i == KMS_XADDR_LOW
             && !(reg_wr_i && reg_addr_i == KMS_REG_SCAN_LO)) begin
            s_nxt.scan_lo = xmove_wdata_i[SCAN_W-1:0]; // [R11]
            scan_wr       = 1'b1;
         end else if (xmove_addr_i == KMS_XADDR_HIGH
                      && !(reg_wr_i && reg_addr_i == KMS_REG_SCAN_HI)) begin
            s_nxt.scan_hi = xmove_wdata_i[SCAN_W-1:0]; // [R11]
            scan_wr       = 1'b1;
         end
      end
      // no bus activity at all in keyboard mode
      if (!kbmode) begin
         s_nxt.xwr   = xmove_wr_i; // [R12]
         s_nxt.xrd   = xmove_rd_i; // [R12]
         s_nxt.xaddr = xmove_addr_i;
         s_nxt.xdata = xmove_wdata_i;
      end else begin
         s_nxt.xaddr = 16'h0000; // [R12]
         s_nxt.xdata = 8'h00;
      end
      // a new scan value starts a step and the measurement window
      if (scan_wr) begin
         s_nxt.step = 1'b1;
         s_nxt.cnt  = CW'(STROBE_CY);
      end else if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
      // power modes
      unique case (s_r.pwr)
         KMS_RUN: begin
            if (s_r.power_control_register[KMS_POWER_CONTROL_REGISTER_PD]) begin
               s_nxt.pwr = KMS_PDOWN; // [R16]
            end else if (s_r.power_control_register[KMS_POWER_CONTROL_REGISTER_IDLE]) begin
               s_nxt.pwr = KMS_IDLE; // [R16]
            end
         end
         KMS_IDLE: begin
            // mechanical key press with irq enabled wakes the cpu
            if (!s_r.variant && s_r.key && irq_zero_enable_i) begin
               s_nxt.pwr                     = KMS_RUN; // [R18]
               s_nxt.power_control_register[KMS_POWER_CONTROL_REGISTER_IDLE]     = 1'b0;
            end
         end
         KMS_PDOWN: begin
            // only reset leaves power-down
            s_nxt.pwr = KMS_PDOWN; // [R17]
         end
         default: begin
            s_nxt.pwr = KMS_RUN;
         end
      endcase
      // key indication and return capture
      if (!s_r.variant) begin
         // mechanical: static level, frozen in power-down (analog off)
         if (s_r.pwr != KMS_PDOWN) begin
            s_nxt.key      = any_pressed; // [R06] [R18]
            s_nxt.ret_hold = s_r.ret_s2; // [R04]
         end
      end else begin
         // capacitive: strobe once at the measurement instant only
         if (s_r.cnt == CW'(1) && s_r.pwr == KMS_RUN) begin
            // 1 = not recharged = key present
            s_nxt.ret_hold = s_r.ret_s2; // [R20] [R04]
            s_nxt.key      = |s_r.ret_s2; // [R07] [R19] [R21]
         end else if (s_r.step) begin
            s_nxt.key = 1'b0; // [R07]
         end
      end
      // register port reads, data valid next cycle
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            KMS_REG_SCAN_LO: s_nxt.rdata = 8'(s_r.scan_lo);
            KMS_REG_SCAN_HI: s_nxt.rdata = 8'(s_r.scan_hi);
            KMS_REG_RETURN:  s_nxt.rdata = 8'(s_r.ret_hold); // [R04]
            KMS_REG_POWER_CONTROL_REGISTER:    s_nxt.rdata = s_r.power_control_register;
            KMS_REG_STATUS: begin
               s_nxt.rdata[KMS_ST_KEY]      = s_r.key; // [R05]
               s_nxt.rdata[KMS_ST_KEYPIN_N] = ~s_r.key;
            end
            KMS_REG_VARIANT: s_nxt.rdata = {7'h00, s_r.variant};
            default:         s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         s_r.scan_lo  <= KMS_SCAN_RST;
         s_r.scan_hi  <= KMS_SCAN_RST;
         s_r.ret_s1   <= '1;
         s_r.ret_s2   <= '1;
         s_r.ret_hold <= '1;
         s_r.key      <= 1'b0;
         s_r.step     <= 1'b0;
         s_r.cnt      <= '0;
         s_r.power_control_register     <= KMS_POWER_CONTROL_REGISTER_RST;
         s_r.variant  <= KMS_VAR_RST;
         s_r.pwr      <= KMS_RUN;
         s_r.rdata    <= 8'h00;
         s_r.xwr      <= 1'b0;
         s_r.xrd      <= 1'b0;
         s_r.xaddr    <= 16'h0000;
         s_r.xdata    <= 8'h00;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_o          = s_r.rdata;
   assign xbus_wr_strobe_o     = s_r.xwr;
   assign xbus_rd_strobe_o     = s_r.xrd;
   assign xbus_addr_o          = s_r.xaddr;
   assign xbus_wdata_o         = s_r.xdata;
   assign scan_out_low_port_o  = s_r.scan_lo;
   assign scan_out_high_port_o = s_r.scan_hi;
   assign key_pressed_pin_n_o  = ~s_r.key; // [R05] [R06]
   // mechanical variant: pin wired externally, internal line idles high
   assign external_interrupt_zero_n_o = s_r.variant ? ~s_r.key : 1'b1; // [R09]
   assign analog_power_on_o    = (s_r.pwr != KMS_PDOWN); // [R17]
   assign cpu_clock_run_o      = (s_r.pwr == KMS_RUN); // [R16]
   assign osc_run_o            = (s_r.pwr != KMS_PDOWN); // [R16]
   assign idle_wake_o = (s_r.pwr == KMS_IDLE) && !s_r.variant
                        && s_r.key && irq_zero_enable_i; // [R18]

   // assertions
   sequence seq_scan_write;
      reg_wr_i && (reg_addr_i == KMS_REG_SCAN_LO);
   endsequence

   a_low_port_write: assert property ( // [R10]
      @(posedge clock_i) disable iff (!rst_n_i)
      seq_scan_write |=> scan_out_low_port_o == $past(reg_wdata_i))
      else $error("low scan port not updated by register write");

   a_xmove_low_addr: assert property ( // [R11]
      @(posedge clock_i) disable iff (!rst_n_i)
      (xmove_wr_i && kbmode && xmove_addr_i == 16'hffff && !reg_wr_i)
      |=> scan_out_low_port_o == $past(xmove_wdata_i))
      else $error("write to ffff did not reach low scan port");

   a_xmove_high_addr: assert property ( // [R11]
      @(posedge clock_i) disable iff (!rst_n_i)
      (xmove_wr_i && kbmode && xmove_addr_i == 16'hfffe && !reg_wr_i)
      |=> scan_out_high_port_o == $past(xmove_wdata_i))
      else $error("write to fffe did not reach high scan port");

   a_kbmode_no_strobe: assert property ( // [R12]
      @(posedge clock_i) disable iff (!rst_n_i)
      kbmode |=> !xbus_wr_strobe_o && !xbus_rd_strobe_o
                 && xbus_addr_o == 16'h0000)
      else $error("bus activity seen in keyboard mode");

   a_std_mode_strobe: assert property ( // [R13]
      @(posedge clock_i) disable iff (!rst_n_i)
      (!kbmode && xmove_wr_i) |=> xbus_wr_strobe_o)
      else $error("standard mode write gave no strobe");

   a_mech_key_level: assert property ( // [R06]
      @(posedge clock_i) disable iff (!rst_n_i)
      (!s_r.variant && s_r.pwr != KMS_PDOWN && $past(!s_r.variant))
      |=> key_pressed_pin_n_o == &($past(s_r.ret_s2)))
      else $error("mechanical key pin does not follow return lines");

   a_pdown_sticky: assert property ( // [R17]
      @(posedge clock_i) disable iff (!rst_n_i)
      (s_r.pwr == KMS_PDOWN) |=> (s_r.pwr == KMS_PDOWN) && !analog_power_on_o)
      else $error("power-down left without reset");

   a_cap_key_hold: assert property ( // [R19]
      @(posedge clock_i) disable iff (!rst_n_i)
      (s_r.variant && $past(s_r.variant) && s_r.cnt == '0 && !s_r.step
       && !scan_wr) |=> $stable(key_pressed_pin_n_o))
      else $error("capacitive key pin changed without a scan write");

   a_cap_irq_route: assert property ( // [R09]
      @(posedge clock_i) disable iff (!rst_n_i)
      s_r.variant |-> external_interrupt_zero_n_o == key_pressed_pin_n_o)
      else $error("capacitive key not routed to interrupt zero");

   a_idle_gates_cpu: assert property ( // [R16]
      @(posedge clock_i) disable iff (!rst_n_i)
      (s_r.pwr == KMS_IDLE) |-> !cpu_clock_run_o && osc_run_o)
      else $error("idle clock gating wrong");

endmodule // kms_scan_detect

// [sim/kms_matrix_model.sv]
// partner model: key switch matrix with comparator return lines
`timescale 1ns/10ps
module kms_matrix_model (
   // scan lines from the device
   input  wire logic [7:0]       scan_lo_i,
   input  wire logic [7:0]       scan_hi_i,
   // closed keys, one byte per scan line
   input  wire logic [15:0][7:0] keys_i,
   input  wire logic             capacitive_i,
   // comparator outputs
   output logic      [7:0]       return_o
);
   logic [15:0] scan_w;
   logic [7:0]  hit_w;
   assign scan_w = {scan_hi_i, scan_lo_i};
   // keys of every low line add up, so a bad scan shows phantom keys
   always_comb begin
      hit_w = 8'h00;
      for (int i = 0; i < 16; i++) begin
         if (!scan_w[i]) begin
            hit_w = hit_w | keys_i[i];
         end
      end
   end
   // capacitive: 1 when not recharged; mechanical: closed switch pulls low
   assign return_o = capacitive_i ? hit_w : ~hit_w;
endmodule // kms_matrix_model

// [sim/tb_keyboard_matrix_scan_detect.sv]
// testbench: keyboard matrix scan and key-press detection
`timescale 1ns/10ps
module tb_keyboard_matrix_scan_detect;
   import kms_pkg::*;
   logic clock_i = 1'b0, rst_n_i = 1'b0;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, xmove_wdata_i = 8'h00;
   logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [15:0] xmove_addr_i = 16'h0000, xbus_addr_o;
   logic        xmove_wr_i = 1'b0, xmove_rd_i = 1'b0, irq_en = 1'b0;
   logic        xbus_wr_strobe_o, xbus_rd_strobe_o, key_n, irq_n;
   logic [7:0]  xbus_wdata_o, scan_lo, scan_hi, ret;
   logic        ana_on, cpu_run, osc_run, wake, cap = 1'b0;
   logic [15:0][7:0] keys = '0;
   int error_cnt = 0, samples_checked = 0;
   always #12.5 clock_i = ~clock_i;
   kms_scan_detect #(.STROBE_CY(4)) dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .xmove_addr_i(xmove_addr_i),
      .xmove_wdata_i(xmove_wdata_i), .xmove_wr_i(xmove_wr_i),
      .xmove_rd_i(xmove_rd_i), .irq_zero_enable_i(irq_en),
      .xbus_wr_strobe_o(xbus_wr_strobe_o),
      .xbus_rd_strobe_o(xbus_rd_strobe_o), .xbus_addr_o(xbus_addr_o),
      .xbus_wdata_o(xbus_wdata_o), .scan_out_low_port_o(scan_lo),
      .scan_out_high_port_o(scan_hi), .return_line_port_i(ret),
      .key_pressed_pin_n_o(key_n), .external_interrupt_zero_n_o(irq_n),
      .analog_power_on_o(ana_on), .cpu_clock_run_o(cpu_run),
      .osc_run_o(osc_run), .idle_wake_o(wake));
   kms_matrix_model mtx (.scan_lo_i(scan_lo), .scan_hi_i(scan_hi),
      .keys_i(keys), .capacitive_i(cap), .return_o(ret));
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clock_i) rst_n_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      rst_n_i <= 1'b1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
      @(posedge clock_i) reg_wr_i <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp,
                         input string what);
      @(posedge clock_i);
      reg_addr_i <= a; reg_rd_i <= 1'b1;
      @(posedge clock_i) reg_rd_i <= 1'b0;
      @(negedge clock_i) check(what, reg_rdata_o, exp);
   endtask
   task automatic xmove(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      xmove_addr_i <= a; xmove_wdata_i <= d; xmove_wr_i <= 1'b1;
      @(posedge clock_i) xmove_wr_i <= 1'b0;
   endtask
   // only one line low, all high in between
   // scan lines reached through the register port
   task automatic scan_line(input int i);
      logic [15:0] v;
      v = ~(16'h0001 << i);
      reg_wr(KMS_REG_SCAN_LO, 8'hff);
      reg_wr(KMS_REG_SCAN_HI, 8'hff);
      reg_wr(KMS_REG_SCAN_LO, v[7:0]);
      reg_wr(KMS_REG_SCAN_HI, v[15:8]);
   endtask
   task automatic t_reset_vals();
      @(negedge clock_i);
      check("scan ports", {scan_hi, scan_lo}, 16'hffff);
      check("key pin", key_n, 1'b1);
      check("strobes", {xbus_wr_strobe_o, xbus_rd_strobe_o}, 2'b00);
      reg_rd(4'hf, 8'h00, "unmapped read");
      $display("test reset values done");
   endtask
   task automatic t_kb_moves();
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h04);
      xmove(KMS_XADDR_LOW, 8'h7f);
      @(negedge clock_i) check("xbus in kb mode", xbus_addr_o, 16'h0000);
      check("low via move", scan_lo, 8'h7f);
      check("no wr strobe", xbus_wr_strobe_o, 1'b0);
      xmove(KMS_XADDR_HIGH, 8'hbf);
      @(negedge clock_i) check("high via move", scan_hi, 8'hbf);
      check("low kept", scan_lo, 8'h7f);
      reg_wr(KMS_REG_SCAN_HI, 8'hfd);
      @(negedge clock_i) check("high via reg", scan_hi, 8'hfd);
      reg_rd(KMS_REG_SCAN_HI, 8'hfd, "high readback");
      $display("test keyboard mode moves done");
   endtask
   task automatic t_std_moves();
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h00);
      xmove(KMS_XADDR_LOW, 8'h3c);
      @(negedge clock_i) check("std wr strobe", xbus_wr_strobe_o, 1'b1);
      check("std addr", xbus_addr_o, KMS_XADDR_LOW);
      check("std data", xbus_wdata_o, 8'h3c);
      check("low untouched", scan_lo, 8'h7f);
      @(negedge clock_i) check("strobe one cycle", xbus_wr_strobe_o, 1'b0);
      $display("test standard mode moves done");
   endtask
   task automatic t_mech_scan();
      keys[10] = 8'h21;
      keys[3] = 8'h80;
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h04);
      for (int i = 0; i < 16; i++) begin
         scan_line(i);
         repeat (6) @(posedge clock_i);
         reg_rd(KMS_REG_RETURN, ~keys[i], "return lines");
         check("key pin", key_n, keys[i] == 8'h00);
         check("irq pin mech", irq_n, 1'b1);
      end
      $display("test mechanical scan done");
   endtask
   task automatic t_mech_idle();
      irq_en <= 1'b1; // cpu side: irq zero enabled
      scan_line(3);
      keys[3] = 8'h00;
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h05);
      repeat (6) @(posedge clock_i);
      @(negedge clock_i) check("cpu gated", {cpu_run, osc_run}, 2'b01);
      keys[3] = 8'h02;
      for (int n = 0; n < 10 && cpu_run !== 1'b1; n++) @(negedge clock_i);
      check("idle woken", cpu_run, 1'b1);
      check("key pin idle", key_n, 1'b0);
      $display("test mechanical idle done");
   endtask
   task automatic t_pdown();
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h06);
      // power state follows the control bit one cycle later
      repeat (2) @(negedge clock_i);
      check("pd osc analog", {osc_run, ana_on}, 2'b00);
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h04);
      @(negedge clock_i) check("pd kept", osc_run, 1'b0);
      do_reset();
      @(negedge clock_i) check("reset exits pd", {osc_run, ana_on}, 2'b11);
      $display("test power-down done");
   endtask
   task automatic t_capacitive();
      keys = '0;
      keys[0] = 8'h02;
      cap = 1'b1;
      reg_wr(KMS_REG_VARIANT, 8'h01);
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h04);
      scan_line(0);
      repeat (12) @(posedge clock_i);
      @(negedge clock_i) check("cap key", key_n, 1'b0);
      check("cap irq route", irq_n, 1'b0);
      reg_rd(KMS_REG_STATUS, 8'h01, "status key flag");
      keys[0] = 8'h00;
      repeat (12) @(posedge clock_i);
      @(negedge clock_i) check("cap holds", key_n, 1'b0);
      scan_line(0);
      repeat (12) @(posedge clock_i);
      @(negedge clock_i) check("cap new scan", key_n, 1'b1);
      reg_wr(KMS_REG_POWER_CONTROL_REGISTER, 8'h05);
      keys[0] = 8'h40;
      repeat (12) @(posedge clock_i);
      @(negedge clock_i);
      check("cap idle", {key_n, wake, cpu_run}, 3'b100);
      $display("test capacitive done");
   endtask
   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      do_reset();
      t_reset_vals();
      t_kb_moves();
      t_std_moves();
      t_mech_scan();
      t_mech_idle();
      t_pdown();
      t_capacitive();
      tally_and_finish();
   end
endmodule // tb_keyboard_matrix_scan_detect
